// *** hdl/wwbc_pkg.sv ***
/*
 * Shared constants and types of the watchdog, wake and bus configuration
 * register bank: register indices, field positions, reset values and the
 * packed carrier of the decoded settings.
 * Assumes a single 50 MHz clock domain and an 8-bit register port.
 */
package wwbc_pkg;

    // ==========================================================
    // Register indices on the serial register port
    localparam logic [6:0] WWBC_ADDR_WATCHDOG = 7'h03;
    localparam logic [6:0] WWBC_ADDR_XCVR0 = 7'h04;
    localparam logic [6:0] WWBC_ADDR_INT_WAKE = 7'h06;
    localparam logic [6:0] WWBC_ADDR_EXT_WAKE = 7'h07;

    // ==========================================================
    // Values after power-on or soft reset
    localparam logic [7:0] WWBC_RST_WATCHDOG = 8'h14;
    localparam logic [7:0] WWBC_RST_XCVR0 = 8'h00;
    localparam logic [7:0] WWBC_RST_INT_WAKE = 8'h01;
    localparam logic [7:0] WWBC_RST_EXT_WAKE = 8'h01;

    // Value forced into the external wake register on fail-safe entry
    localparam logic [7:0] WWBC_FS_EXT_WAKE = 8'h01;

    // ==========================================================
    // Writable bit masks; everything else reads as zero
    localparam logic [7:0] WWBC_MASK_WATCHDOG = 8'hff;
    localparam logic [7:0] WWBC_MASK_XCVR0 = 8'h03;
    localparam logic [7:0] WWBC_MASK_INT_WAKE = 8'h75;
    localparam logic [7:0] WWBC_MASK_EXT_WAKE = 8'h01;

    // Restart: bits kept in the watchdog and internal wake registers, and forced values in the watchdog register
    localparam logic [7:0] WWBC_RSK_WATCHDOG = 8'hb8;
    localparam logic [7:0] WWBC_RSV_WATCHDOG = 8'h04;
    localparam logic [7:0] WWBC_RSK_INT_WAKE = 8'h71;

    // ==========================================================
    // Field positions
    localparam int WWBC_WD_CHECKSUM = 7;
    localparam int WWBC_WD_STOP_OFF_A = 6;
    localparam int WWBC_WD_TYPE = 5;
    localparam int WWBC_WD_BUS_WAKE = 4;
    localparam int WWBC_WD_RST_LIMIT = 3;
    localparam int WWBC_WD_PERIOD_LSB = 0;
    localparam int WWBC_IW_CYCLIC = 6;
    localparam int WWBC_IW_THRESH_LSB = 4;
    localparam int WWBC_IW_STOP_OFF_B = 2;
    localparam int WWBC_IW_FAST_BATT = 0;
    localparam int WWBC_EW_WAKE_PIN = 0;

    // ==========================================================
    // Watchdog period codes and their times in ms
    localparam logic [2:0] WWBC_PER_UNDEF = 3'h6;
    localparam logic [9:0] WWBC_PER_MS_0 = 10'd10;
    localparam logic [9:0] WWBC_PER_MS_1 = 10'd20;
    localparam logic [9:0] WWBC_PER_MS_2 = 10'd50;
    localparam logic [9:0] WWBC_PER_MS_3 = 10'd100;
    localparam logic [9:0] WWBC_PER_MS_4 = 10'd200;
    localparam logic [9:0] WWBC_PER_MS_5 = 10'd500;
    localparam logic [9:0] WWBC_PER_MS_7 = 10'd1000;

    // Transceiver mode codes
    localparam logic [1:0] WWBC_XM_OFF = 2'h0;
    localparam logic [1:0] WWBC_XM_WAKE = 2'h1;
    localparam logic [1:0] WWBC_XM_RX_ONLY = 2'h2;
    localparam logic [1:0] WWBC_XM_NORMAL = 2'h3;

    // Consecutive watchdog resets allowed when limiting is on
    localparam logic [1:0] WWBC_RST_LIMIT_CNT = 2'd3;

    // Synchroniser depth for pin inputs
    localparam int WWBC_SYNC_STAGES = 2;

    // ==========================================================
    // Decoded settings handed to the rest of the chip
    typedef struct packed {
        logic stop_watchdog_off_a;
        logic stop_watchdog_off_b;
        logic watchdog_type_select;
        logic watchdog_start_on_bus_wake;
        logic reset_limit;
        logic [2:0] watchdog_period;
        logic [1:0] transceiver0_mode;
        logic cyclic_wake_enable;
        logic [1:0] battery_threshold_select;
        logic fast_battery_monitor_enable;
        logic wake_pin_source_enable;
    } wwbc_cfg_t;

    // Register read or write request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } wwbc_req_t;

endpackage : wwbc_pkg

// *** hdl/wwbc_sync.sv ***
/*
 * Two-stage level synchroniser, parameterised in width.
 * Assumes inputs are asynchronous levels; only the second stage is read.
 */
`timescale 1ns/1ps
module wwbc_sync
    import wwbc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // ==========================================================
    // Two flip-flops in series
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule : wwbc_sync

// *** hdl/wwbc_regs.sv ***
/*
 * Watchdog, wake source and transceiver 0 configuration register bank.
 * Holds four 8-bit registers written and read by the host over the
 * register port behind the serial interface, applies reset, restart and
 * fail-safe overrides, and decodes watchdog reset limiting.
 * Assumes the serial framing, mode control and watchdog timer sit outside
 * on the same clock; only the interrupt pin level is asynchronous.
 */
`timescale 1ns/1ps

// Summary of operation
// - Watchdog register bit 6 set together with internal wake bit 2 turns the watchdog off in Stop Mode.
// - Internal wake bit 2 set together with watchdog register bit 6 turns the watchdog off in Stop Mode.
// - Watchdog type bit: 0 time-out watchdog, 1 window watchdog.
// - Bus wake in Stop Mode starts watchdog with long window if enabled.
// - Reset limit bit stops resets after three consecutive watchdog resets in configuration 1/3.
// - Period codes 10 to 1000 ms; code 110 has no defined period.
// - Transceiver 0 mode: off, wake capable, receive only, normal.
// - Fail-safe entry rewrites bus and wake registers to keep wake possible.
// - Fail-safe entry forces external wake register to 0000 0001.
// - Internal wake bit 6 enables the cyclic timer wake source.
// - Two-bit battery threshold select, 00 is highest threshold.
// - Internal wake bit 0 enables fast battery voltage monitoring.
// - External wake bit 0 enables the wake pin as wake source.
// - Reserved bits always read back as zero.
// - Watchdog register resets to 0x14; restart clears bit 6, period 200.
// - Internal wake resets to 0x01; restart clears bit 7 and bits 3:1.
// - A direct Stop to Sleep request is not honoured.
// - Interrupt pin level selects configuration 1/3 or 2/4.
module wwbc_regs
    import wwbc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire wwbc_req_t req_i,
    input wire logic soft_reset_i,
    input wire logic restart_i,
    input wire logic stop_mode_i,
    input wire logic sleep_req_i,
    input wire logic bus_wake_i,
    input wire logic wd_fail_i,
    input wire logic wd_trigger_ok_i,
    input wire logic failure_failsafe_i,
    input wire logic interrupt_pin_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic wd_parity_error_o,
    output wwbc_cfg_t cfg_o,
    output logic watchdog_run_o,
    output logic [9:0] wd_period_ms_o,
    output logic wd_period_valid_o,
    output logic wd_long_window_o,
    output logic wd_reset_req_o,
    output logic failsafe_req_o,
    output logic sleep_grant_o
);

    // ==========================================================
    // Register storage and internal signals
    logic [7:0] watchdog_configuration;
    logic [7:0] transceiver0_mode_control;
    logic [7:0] internal_wake_control;
    logic [7:0] external_wake_control;
    logic [1:0] wd_reset_count;
    logic int_pin_sync;
    logic cfg_failsafe;
    logic failsafe_entry;
    logic wd_write;
    logic parity_ok;
    logic next_reset_allowed;

    // Interrupt pin is an asynchronous strap-like level
    wwbc_sync #(
        .WIDTH(1)
    ) u_int_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(interrupt_pin_i),
        .sync_o(int_pin_sync)
    );

    // ==========================================================
    // Decode of write, parity and fail-safe conditions
    assign wd_write = req_i.wr && (req_i.addr == WWBC_ADDR_WATCHDOG);
    assign parity_ok = ~(^req_i.wdata);
    // High pin selects configuration 2/4: watchdog failure goes fail-safe
    assign cfg_failsafe = int_pin_sync;
    assign failsafe_entry = failure_failsafe_i
        | (wd_fail_i & cfg_failsafe);
    // Limit applies only in configuration 1/3
    assign next_reset_allowed = ~(watchdog_configuration[WWBC_WD_RST_LIMIT]
        & ~cfg_failsafe
        & (wd_reset_count >= WWBC_RST_LIMIT_CNT));

    // ==========================================================
    // Watchdog configuration register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            watchdog_configuration <= WWBC_RST_WATCHDOG;
        end else if (soft_reset_i) begin
            watchdog_configuration <= WWBC_RST_WATCHDOG;
        end else if (restart_i) begin
            watchdog_configuration <= (watchdog_configuration
                & WWBC_RSK_WATCHDOG) | WWBC_RSV_WATCHDOG;
        end else if (wd_write && parity_ok) begin
            watchdog_configuration <= req_i.wdata & WWBC_MASK_WATCHDOG;
        end
    end

    // Parity error flag, set on a rejected write, cleared by a good one
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_parity_error_o <= 1'b0;
        end else if (soft_reset_i) begin
            wd_parity_error_o <= 1'b0;
        end else if (wd_write) begin
            wd_parity_error_o <= ~parity_ok;
        end
    end

    // ==========================================================
    // Transceiver 0 mode register; fail-safe leaves it wake capable
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            transceiver0_mode_control <= WWBC_RST_XCVR0;
        end else if (soft_reset_i) begin
            transceiver0_mode_control <= WWBC_RST_XCVR0;
        end else if (failsafe_entry) begin
            transceiver0_mode_control <= {6'h00, WWBC_XM_WAKE};
        end else if (req_i.wr && req_i.addr == WWBC_ADDR_XCVR0) begin
            transceiver0_mode_control <= req_i.wdata & WWBC_MASK_XCVR0;
        end
    end

    // ==========================================================
    // Internal wake control register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            internal_wake_control <= WWBC_RST_INT_WAKE;
        end else if (soft_reset_i) begin
            internal_wake_control <= WWBC_RST_INT_WAKE;
        end else if (restart_i) begin
            internal_wake_control <= internal_wake_control
                & WWBC_RSK_INT_WAKE;
        end else if (req_i.wr && req_i.addr == WWBC_ADDR_INT_WAKE) begin
            internal_wake_control <= req_i.wdata
                & WWBC_MASK_INT_WAKE;
        end
    end

    // ==========================================================
    // External wake control register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            external_wake_control <= WWBC_RST_EXT_WAKE;
        end else if (soft_reset_i) begin
            external_wake_control <= WWBC_RST_EXT_WAKE;
        end else if (failsafe_entry) begin
            external_wake_control <= WWBC_FS_EXT_WAKE;
        end else if (req_i.wr && req_i.addr == WWBC_ADDR_EXT_WAKE) begin
            external_wake_control <= req_i.wdata
                & WWBC_MASK_EXT_WAKE;
        end
    end

    // ==========================================================
    // Read port: one cycle latency, unmapped and reserved bits read zero
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                unique case (req_i.addr)
                    WWBC_ADDR_WATCHDOG: rdata_o <= watchdog_configuration;
                    WWBC_ADDR_XCVR0: rdata_o <= transceiver0_mode_control
                        & WWBC_MASK_XCVR0;
                    WWBC_ADDR_INT_WAKE: rdata_o <= internal_wake_control
                        & WWBC_MASK_INT_WAKE;
                    WWBC_ADDR_EXT_WAKE: rdata_o <= external_wake_control
                        & WWBC_MASK_EXT_WAKE;
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // Decoded settings, taken straight from register bits
    assign cfg_o.stop_watchdog_off_a =
        watchdog_configuration[WWBC_WD_STOP_OFF_A];
    assign cfg_o.stop_watchdog_off_b =
        internal_wake_control[WWBC_IW_STOP_OFF_B];
    assign cfg_o.watchdog_type_select =
        watchdog_configuration[WWBC_WD_TYPE];
    assign cfg_o.watchdog_start_on_bus_wake =
        watchdog_configuration[WWBC_WD_BUS_WAKE];
    assign cfg_o.reset_limit = watchdog_configuration[WWBC_WD_RST_LIMIT];
    assign cfg_o.watchdog_period =
        watchdog_configuration[WWBC_WD_PERIOD_LSB +: 3];
    assign cfg_o.transceiver0_mode = transceiver0_mode_control[1:0];
    assign cfg_o.cyclic_wake_enable =
        internal_wake_control[WWBC_IW_CYCLIC];
    assign cfg_o.battery_threshold_select =
        internal_wake_control[WWBC_IW_THRESH_LSB +: 2];
    assign cfg_o.fast_battery_monitor_enable =
        internal_wake_control[WWBC_IW_FAST_BATT];
    assign cfg_o.wake_pin_source_enable =
        external_wake_control[WWBC_EW_WAKE_PIN];

    // ==========================================================
    // Watchdog run enable: off in Stop Mode only when both bits are set
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            watchdog_run_o <= 1'b1;
        end else begin
            watchdog_run_o <= ~(stop_mode_i
                & watchdog_configuration[WWBC_WD_STOP_OFF_A]
                & internal_wake_control[WWBC_IW_STOP_OFF_B]);
        end
    end

    // ==========================================================
    // Period decode in ms; code 110 flagged as undefined
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_period_ms_o <= WWBC_PER_MS_4;
            wd_period_valid_o <= 1'b1;
        end else begin
            wd_period_valid_o <= (cfg_o.watchdog_period
                != WWBC_PER_UNDEF);
            unique case (cfg_o.watchdog_period)
                3'h0: wd_period_ms_o <= WWBC_PER_MS_0;
                3'h1: wd_period_ms_o <= WWBC_PER_MS_1;
                3'h2: wd_period_ms_o <= WWBC_PER_MS_2;
                3'h3: wd_period_ms_o <= WWBC_PER_MS_3;
                3'h4: wd_period_ms_o <= WWBC_PER_MS_4;
                3'h5: wd_period_ms_o <= WWBC_PER_MS_5;
                3'h6: wd_period_ms_o <= 10'h000;
                3'h7: wd_period_ms_o <= WWBC_PER_MS_7;
            endcase
        end
    end

    // ==========================================================
    // Long open window start after a bus wake in Stop Mode
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_long_window_o <= 1'b0;
        end else begin
            wd_long_window_o <= bus_wake_i & stop_mode_i
                & watchdog_configuration[WWBC_WD_BUS_WAKE];
        end
    end

    // ==========================================================
    // Consecutive watchdog reset counter; a good trigger clears it
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_reset_count <= 2'd0;
        end else if (soft_reset_i) begin
            wd_reset_count <= 2'd0;
        end else if (wd_fail_i && !cfg_failsafe) begin
            if (wd_reset_count < WWBC_RST_LIMIT_CNT) begin
                wd_reset_count <= wd_reset_count + 2'd1;
            end
        end else if (wd_trigger_ok_i) begin
            wd_reset_count <= 2'd0;
        end
    end

    // Reset request on a watchdog failure; fail-safe request on a failure or a watchdog failure in configuration 2/4
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_reset_req_o <= 1'b0;
            failsafe_req_o <= 1'b0;
        end else begin
            wd_reset_req_o <= wd_fail_i & next_reset_allowed;
            failsafe_req_o <= failsafe_entry;
        end
    end

    // ==========================================================
    // Sleep request is refused while in Stop Mode
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sleep_grant_o <= 1'b0;
        end else begin
            sleep_grant_o <= sleep_req_i & ~stop_mode_i;
        end
    end

endmodule : wwbc_regs

// *** dv/wwbc_host.sv ***
/* Host model that issues single-byte register requests.
   Assumes the bench raises go_i for one cycle per request. */
`timescale 1ns/1ps
module wwbc_host
    import wwbc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic go_i,
    input wire logic rd_i,
    input wire logic bad_parity_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] data_i,
    output wwbc_req_t req_o
);
    // ==========
    // Request launch; idle lines toggle so stale values never look valid
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_o <= '0;
        end else if (go_i) begin
            req_o.wr <= !rd_i;
            req_o.rd <= rd_i;
            req_o.addr <= addr_i;
            req_o.wdata <= (addr_i == WWBC_ADDR_WATCHDOG) ?
                {(^data_i[6:0]) ^ bad_parity_i, data_i[6:0]} : data_i;
        end else begin
            req_o <= {2'b00, ~req_o.addr, ~req_o.wdata};
        end
    end
endmodule : wwbc_host

// *** dv/wwbc_regs_asserts.sv ***
/* Port-level checks of the configuration register bank.
   Assumes one clock domain and the asynchronous active-high reset. */
`timescale 1ns/1ps
module wwbc_regs_asserts
    import wwbc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire wwbc_req_t req_i,
    input wire logic soft_reset_i,
    input wire logic restart_i,
    input wire logic stop_mode_i,
    input wire logic sleep_req_i,
    input wire logic bus_wake_i,
    input wire logic wd_fail_i,
    input wire logic failure_failsafe_i,
    input wire logic interrupt_pin_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic wd_parity_error_o,
    input wire wwbc_cfg_t cfg_o,
    input wire logic watchdog_run_o,
    input wire logic [9:0] wd_period_ms_o,
    input wire logic wd_period_valid_o,
    input wire logic wd_long_window_o,
    input wire logic wd_reset_req_o,
    input wire logic failsafe_req_o,
    input wire logic sleep_grant_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ==========
    // Helpers: reserved masks, period table, stop-off condition
    function automatic logic [7:0] resv_mask(input logic [6:0] a);
        case (a)
            7'h03: return 8'h00;
            7'h04: return 8'hfc;
            7'h06: return 8'h8a;
            7'h07: return 8'hfe;
            default: return 8'hff;
        endcase
    endfunction : resv_mask
    logic [9:0] ms_tab [8];
    assign ms_tab = '{10'h00a, 10'h014, 10'h032, 10'h064,
                      10'h0c8, 10'h1f4, 10'h000, 10'h3e8};
    wire logic stop_off = stop_mode_i && cfg_o.stop_watchdog_off_a &&
        cfg_o.stop_watchdog_off_b;
    sequence s_wd_write;
        req_i.wr && req_i.addr == 7'h03 && !soft_reset_i && !restart_i;
    endsequence

    // ==========
    // Assertions
    a_read_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    a_reserved_zero: assert property (
        req_i.rd |=> (rdata_o & resv_mask($past(req_i.addr))) == 8'h00)
        else $error("reserved bits read nonzero");
    a_parity_flag: assert property (
        s_wd_write |=> wd_parity_error_o == ^$past(req_i.wdata))
        else $error("parity flag wrong");
    a_parity_keep: assert property (
        s_wd_write ##0 ^req_i.wdata |=> $stable(cfg_o.watchdog_period))
        else $error("odd parity write took effect");
    a_period_map: assert property (
        wd_period_ms_o == ms_tab[$past(cfg_o.watchdog_period)] &&
        wd_period_valid_o == ($past(cfg_o.watchdog_period) != 3'h6))
        else $error("period decode wrong");
    a_stop_off: assert property (stop_off [*2] |-> !watchdog_run_o)
        else $error("watchdog runs in stop");
    a_stop_on: assert property (!stop_off [*2] |-> watchdog_run_o)
        else $error("watchdog stopped wrongly");
    a_long_window: assert property (
        1'b1 |=> wd_long_window_o == $past(bus_wake_i && stop_mode_i &&
        cfg_o.watchdog_start_on_bus_wake))
        else $error("long window wrong");
    a_sleep_grant: assert property (
        sleep_req_i |=> sleep_grant_o == !$past(stop_mode_i))
        else $error("sleep grant wrong");
    a_wd_reset: assert property (
        (!interrupt_pin_i) [*3] ##0 (wd_fail_i && !cfg_o.reset_limit)
        |=> wd_reset_req_o)
        else $error("watchdog reset missing");
    a_failsafe_wake: assert property (
        failure_failsafe_i && !soft_reset_i |=> failsafe_req_o &&
        cfg_o.wake_pin_source_enable && cfg_o.transceiver0_mode == 2'h1)
        else $error("fail-safe wake setup wrong");
endmodule : wwbc_regs_asserts

// *** dv/tb_wwbc_regs.sv ***
/* Self-checking bench of the configuration register bank.
   Assumes the host model and checker are compiled before this file. */
`timescale 1ns/1ps
module tb_wwbc_regs
    import wwbc_pkg::*;
;
    // ==========
    // Stimulus and observation signals
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic go = 1'b0, rd = 1'b0, bad = 1'b0, stop = 1'b0, pin = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] data = 8'h00;
    logic [6:0] ev = 7'h00;
    wwbc_req_t req;
    wwbc_cfg_t cfg;
    logic [7:0] rdata, rd_seen;
    logic rvalid, perr, run, pvalid, lwin, rreq, fsreq, grant;
    logic [9:0] ms;
    logic [9:0] ms_tab [8] = '{10'h00a, 10'h014, 10'h032, 10'h064,
                               10'h0c8, 10'h1f4, 10'h000, 10'h3e8};
    int num_errors = 0;
    int comparisons = 0;
    localparam int ev_srst = 0, ev_rstrt = 1, ev_sleep = 2, ev_bwake = 3;
    localparam int ev_fail = 4, ev_tok = 5, ev_fs = 6;

    // Clock of 20 ns
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    wwbc_regs DUT (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
        .soft_reset_i(ev[0]), .restart_i(ev[1]), .stop_mode_i(stop),
        .sleep_req_i(ev[2]), .bus_wake_i(ev[3]), .wd_fail_i(ev[4]),
        .wd_trigger_ok_i(ev[5]), .failure_failsafe_i(ev[6]),
        .interrupt_pin_i(pin), .rdata_o(rdata), .rvalid_o(rvalid),
        .wd_parity_error_o(perr), .cfg_o(cfg), .watchdog_run_o(run),
        .wd_period_ms_o(ms), .wd_period_valid_o(pvalid),
        .wd_long_window_o(lwin), .wd_reset_req_o(rreq),
        .failsafe_req_o(fsreq), .sleep_grant_o(grant)
    );
    wwbc_host u_host (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .rd_i(rd),
        .bad_parity_i(bad), .addr_i(addr), .data_i(data), .req_o(req)
    );

    // ==========
    // Tasks
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic issue(input logic r, input logic [6:0] a,
                         input logic [7:0] d, input logic b);
        @(posedge ref_clk_i);
        go <= 1'b1;
        rd <= r;
        addr <= a;
        data <= d;
        bad <= b;
        @(posedge ref_clk_i);
        go <= 1'b0;
        bad <= 1'b0;
        @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        rd_seen = (rvalid === 1'b1) ? rdata : 8'hxx;
        @(negedge ref_clk_i);
    endtask : issue
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        issue(1'b0, a, d, 1'b0);
    endtask : wr
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        issue(1'b1, a, 8'h00, 1'b0);
        check({2'b00, rd_seen}, {2'b00, exp});
    endtask : rd_chk
    task automatic fire(input int i);
        @(posedge ref_clk_i);
        ev[i] <= 1'b1;
        @(posedge ref_clk_i);
        ev[i] <= 1'b0;
        @(negedge ref_clk_i);
    endtask : fire
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog against a hang
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    // ==========
    // Test sequence
    initial begin
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(7'h03, 8'h14);
        rd_chk(7'h04, 8'h00);
        rd_chk(7'h06, 8'h01);
        rd_chk(7'h07, 8'h01);
        rd_chk(7'h05, 8'h00);
        $display("test reset values done");
        wr(7'h06, 8'hff);
        rd_chk(7'h06, 8'h75);
        wr(7'h07, 8'hfe);
        rd_chk(7'h07, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(7'h04, {6'h3f, 2'(m)});
            wr(7'h06, {2'h0, 2'(m), 4'h0});
            check(10'(cfg.transceiver0_mode), 10'(m));
            check(10'(cfg.battery_threshold_select), 10'(m));
            check(10'(cfg.cyclic_wake_enable), 10'h000);
        end
        rd_chk(7'h04, 8'h03);
        $display("test field access done");
        for (int c = 0; c < 8; c++) begin
            wr(7'h03, {5'h02, 3'(c)});
            check(ms, ms_tab[c]);
            check(10'(pvalid), (c == 6) ? 10'h000 : 10'h001);
            check(10'(perr), 10'h000);
        end
        issue(1'b0, 7'h03, 8'h11, 1'b1);
        check(10'(perr), 10'h001);
        rd_chk(7'h03, 8'h17);
        $display("test periods and parity done");
        wr(7'h03, 8'h7b);
        check(10'(cfg.watchdog_type_select), 10'h001);
        wr(7'h06, 8'hff);
        @(posedge ref_clk_i) stop <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check(10'(run), 10'h000);
        fire(ev_rstrt);
        rd_chk(7'h03, 8'h3c);
        rd_chk(7'h06, 8'h71);
        rd_chk(7'h04, 8'h03);
        wr(7'h03, 8'h54);
        check(10'(run), 10'h001);
        fire(ev_bwake);
        check(10'(lwin), 10'h001);
        fire(ev_sleep);
        check(10'(grant), 10'h000);
        wr(7'h03, 8'h44);
        fire(ev_bwake);
        check(10'(lwin), 10'h000);
        @(posedge ref_clk_i) stop <= 1'b0;
        fire(ev_sleep);
        check(10'(grant), 10'h001);
        fire(ev_srst);
        rd_chk(7'h03, 8'h14);
        rd_chk(7'h06, 8'h01);
        rd_chk(7'h04, 8'h00);
        $display("test modes and overrides done");
        repeat (4) fire(ev_fail);
        check(10'(rreq), 10'h001);
        wr(7'h03, 8'h1c);
        fire(ev_tok);
        for (int k = 0; k < 5; k++) begin
            fire(ev_fail);
            check(10'(rreq), (k < 3) ? 10'h001 : 10'h000);
        end
        fire(ev_tok);
        fire(ev_fail);
        check(10'(rreq), 10'h001);
        wr(7'h04, 8'h03);
        wr(7'h07, 8'h00);
        pin <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        fire(ev_fail);
        check(10'(fsreq), 10'h001);
        rd_chk(7'h07, 8'h01);
        rd_chk(7'h04, 8'h01);
        pin <= 1'b0;
        wr(7'h07, 8'h00);
        fire(ev_fs);
        check(10'(fsreq), 10'h001);
        rd_chk(7'h07, 8'h01);
        $display("test failures done");
        report_and_stop();
    end
endmodule : tb_wwbc_regs

bind wwbc_regs wwbc_regs_asserts u_asserts (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .soft_reset_i(soft_reset_i), .restart_i(restart_i),
    .stop_mode_i(stop_mode_i), .sleep_req_i(sleep_req_i),
    .bus_wake_i(bus_wake_i), .wd_fail_i(wd_fail_i),
    .failure_failsafe_i(failure_failsafe_i),
    .interrupt_pin_i(interrupt_pin_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .wd_parity_error_o(wd_parity_error_o),
    .cfg_o(cfg_o), .watchdog_run_o(watchdog_run_o),
    .wd_period_ms_o(wd_period_ms_o), .wd_period_valid_o(wd_period_valid_o),
    .wd_long_window_o(wd_long_window_o), .wd_reset_req_o(wd_reset_req_o),
    .failsafe_req_o(failsafe_req_o), .sleep_grant_o(sleep_grant_o)
);
